// *** inc/wrfod_cfg.svh ***
// Constants for the wireless receiver FOD and host-pin block.
// Assumes inclusion by bare name; definitions only.
`ifndef WRFOD_CFG_SVH
`define WRFOD_CFG_SVH

// Register indices (word address = index)
`define WRFOD_REG_CTRL       8'h00
`define WRFOD_REG_STATUS     8'h01
`define WRFOD_REG_QREF       8'h02
`define WRFOD_REG_DELTA      8'h03
`define WRFOD_REG_SPLIT      8'h04
`define WRFOD_REG_LIM_HI     8'h05
`define WRFOD_REG_LIM_LO     8'h06
`define WRFOD_REG_RPT        8'h07
`define WRFOD_REG_SECTION    8'h08
`define WRFOD_REG_FOD_FIRST  8'h68
`define WRFOD_REG_FOD_LAST   8'h77

// CTRL bit positions
`define WRFOD_CTRL_EXT       0
`define WRFOD_CTRL_PG_REG    1
`define WRFOD_CTRL_HI_VOUT   2
`define WRFOD_CTRL_ALERT_CLR 3

// Reset values
`define WRFOD_QREF_RST       16'h001E
`define WRFOD_DELTA_RST      16'h01F4
`define WRFOD_SPLIT_RST      16'h1388
`define WRFOD_LIM_HI_RST     16'h02BC
`define WRFOD_LIM_LO_RST     16'h01F4
`define WRFOD_GAIN_RST       8'h80
`define WRFOD_OFS_RST        8'h00

// Load current thresholds in mA
`define WRFOD_I_DIODE        16'h0064
`define WRFOD_I_SPLIT_LO     16'h0118
`define WRFOD_I_SPLIT_HI     16'h017C
`define WRFOD_I_380          16'h017C
`define WRFOD_I_510          16'h01FE
`define WRFOD_I_670          16'h029E
`define WRFOD_I_870          16'h0366
`define WRFOD_I_HYST         16'h001E

// Timing
`define WRFOD_CLK_MHZ        125
`define WRFOD_RAMP_MS        2000
`define WRFOD_RAMP_CYC       (`WRFOD_RAMP_MS * 1000 * `WRFOD_CLK_MHZ)
`define WRFOD_RPT_US         50
`define WRFOD_RPT_CYC        (`WRFOD_RPT_US * `WRFOD_CLK_MHZ)

`endif

// *** inc/wrfod_pkg.sv ***
// Types for the wireless receiver FOD and host-pin block.
// Assumes nothing beyond a SystemVerilog compiler.
package wrfod_pkg;
  typedef enum logic [2:0] {
    WRFOD_IDLE   = 3'b000,
    WRFOD_NEGO   = 3'b001,
    WRFOD_RAMP   = 3'b010,
    WRFOD_XFER   = 3'b011,
    WRFOD_SHARE  = 3'b100,
    WRFOD_END    = 3'b101
  } wrfod_state_t;

  typedef enum logic [1:0] {
    WRFOD_PKT_NONE = 2'b00,
    WRFOD_PKT_QREF = 2'b01,
    WRFOD_PKT_RPP  = 2'b10,
    WRFOD_PKT_EPT  = 2'b11
  } wrfod_pkt_t;

  typedef struct packed {
    wrfod_pkt_t  kind;
    logic [15:0] value;
  } wrfod_packet_t;

  typedef struct packed {
    logic        ocp;
    logic        ovp;
    logic        otp;
  } wrfod_faults_t;
endpackage

// *** logic/wrfod_core.sv ***
// Receiver FOD section selection, reported power, share-mode FOD and host pins.
// Assumes analogue measurements arrive from logic on sys_clk; pins are synchronised here.
//
// Notes on behaviour
// - Pull host_alert_n low on major state change or fault.
// - Inhibit low enables reception; high blocks any new connection; auto-start share mode still starts while inhibited.
// - Inhibit high during transfer sends end packet; protection stays on.
// - Power good low by default; basic profile raises it at regulator enable.
// - Extended profile raises power good after negotiation, or optionally at regulator enable.
// - Auto-start input high starts share mode once external output power appears.
// - Extended profile sends reference quality factor, default 30, during negotiation.
// - During transfer, repeatedly send received power reports in both profiles.
// - Reported power is determined power plus accuracy margin.
// - Eight detection sections, each with gain and offset, selected by load.
// - Section 3 510-670mA, 4 670-870mA, 5 above 870mA.
// - Extended: 6 diode below 100mA, 0 to split, 2 split to 510mA.
// - Basic: 0 to split, 1 split to 380mA, 2 380-510mA.
// - Split current 280mA below 7V output setting, 380mA above.
// - About 30mA hysteresis on every section change.
// - Sections 0-5 report delivered power times gain plus offset.
// - Share mode stops transfer when transmitted minus partner power exceeds threshold.
// - Share threshold chosen from partner power using split and two limits.
// - Basic: enable regulator at rectifier target or two-second timeout.
`timescale 1ns/1ps
`default_nettype none
`include "wrfod_cfg.svh"

module wrfod_core #(
  parameter int unsigned RAMP_CYC = `WRFOD_RAMP_CYC
) (
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  input  wire logic                   clk_en,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [15:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [15:0]                 reg_rdata,
  input  wire logic                   transfer_inhibit,
  input  wire logic                   share_mode_autostart,
  input  wire logic                   field_present,
  input  wire logic                   nego_done,
  input  wire logic                   rect_at_target,
  input  wire logic                   ext_vout_present,
  input  wire logic                   share_pt_valid,
  input  wire logic [15:0]            load_ma,
  input  wire logic [15:0]            power_mw,
  input  wire logic [15:0]            tx_power_mw,
  input  wire logic [15:0]            partner_rpp_mw,
  input  wire wrfod_pkg::wrfod_faults_t faults,
  output logic                        host_alert_n_o,
  output logic                        host_alert_n_oe,
  output logic                        power_good_out,
  output logic                        main_regulator_en,
  output logic                        rect_protect_en,
  output logic                        share_active,
  output wrfod_pkg::wrfod_packet_t    pkt_q,
  output logic                        pkt_valid
);
  // Pin synchronisers
  // Only the second stage is read, so a metastable first stage never spreads
  logic [1:0] inh_s_q;
  logic [1:0] auto_s_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      inh_s_q  <= 2'b00;
      auto_s_q <= 2'b00;
    end else if (clk_en) begin
      inh_s_q  <= {inh_s_q[0], transfer_inhibit};
      auto_s_q <= {auto_s_q[0], share_mode_autostart};
    end
  end
  wire inhibit = inh_s_q[1];
  wire autost  = auto_s_q[1];

  // Registers
  logic [3:0]  ctrl_q;
  logic [15:0] qref_q, delta_q, split_q, lim_hi_q, lim_lo_q;
  logic [7:0]  gain_q [0:7];
  logic [7:0]  ofs_q  [0:7];
  logic        alert_q;
  logic        fod_trip_q;
  logic [15:0] rpt_q;
  logic [2:0]  sect_q;
  wrfod_pkg::wrfod_state_t st_q, st_d;

  wire ext_prof = ctrl_q[`WRFOD_CTRL_EXT];
  wire wr_ctrl  = reg_wr && (reg_addr == `WRFOD_REG_CTRL);
  wire wr_fod   = reg_wr && (reg_addr >= `WRFOD_REG_FOD_FIRST) && (reg_addr <= `WRFOD_REG_FOD_LAST);
  wire [7:0] fod_rel = reg_addr - `WRFOD_REG_FOD_FIRST;
  wire [2:0] fod_idx = fod_rel[3:1];

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl_q   <= 4'h0;
      qref_q   <= `WRFOD_QREF_RST;
      delta_q  <= `WRFOD_DELTA_RST;
      split_q  <= `WRFOD_SPLIT_RST;
      lim_hi_q <= `WRFOD_LIM_HI_RST;
      lim_lo_q <= `WRFOD_LIM_LO_RST;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == `WRFOD_REG_CTRL)
        ctrl_q <= {1'b0, reg_wdata[2:0]};
      else if (reg_addr == `WRFOD_REG_QREF)
        qref_q <= reg_wdata;
      else if (reg_addr == `WRFOD_REG_DELTA)
        delta_q <= reg_wdata;
      else if (reg_addr == `WRFOD_REG_SPLIT)
        split_q <= reg_wdata;
      else if (reg_addr == `WRFOD_REG_LIM_HI)
        lim_hi_q <= reg_wdata;
      else if (reg_addr == `WRFOD_REG_LIM_LO)
        lim_lo_q <= reg_wdata;
    end
  end

  // Gain and offset per section; even word gain, odd word offset
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < 8; i++) begin
        gain_q[i] <= `WRFOD_GAIN_RST;
        ofs_q[i]  <= `WRFOD_OFS_RST;
      end
    end else if (clk_en && wr_fod) begin
      if (fod_rel[0])
        ofs_q[fod_idx] <= reg_wdata[7:0];
      else
        gain_q[fod_idx] <= reg_wdata[7:0];
    end
  end

  // Section selection with hysteresis
  wire [15:0] split_ma = ctrl_q[`WRFOD_CTRL_HI_VOUT] ? `WRFOD_I_SPLIT_HI : `WRFOD_I_SPLIT_LO;

  // Raw section for one load value; the caller applies the hysteresis
  function automatic logic [2:0] raw_section(input logic [15:0] i, input logic ext, input logic [15:0] sp);
    if (i >= `WRFOD_I_870)
      raw_section = 3'd5;
    else if (i >= `WRFOD_I_670)
      raw_section = 3'd4;
    else if (i >= `WRFOD_I_510)
      raw_section = 3'd3;
    else if (ext)
      raw_section = (i < `WRFOD_I_DIODE) ? 3'd6 : ((i < sp) ? 3'd0 : 3'd2);
    else
      raw_section = (i < sp) ? 3'd0 : ((i < `WRFOD_I_380) ? 3'd1 : 3'd2);
  endfunction

  wire [15:0] load_up = (load_ma > `WRFOD_I_HYST) ? load_ma - `WRFOD_I_HYST : 16'h0000;
  wire [15:0] load_dn = (load_ma < 16'hFFE1) ? load_ma + `WRFOD_I_HYST : 16'hFFFF;
  wire [2:0]  sect_raw = raw_section(load_ma, ext_prof, split_ma);
  wire [2:0]  sect_lo  = raw_section(load_up, ext_prof, split_ma);
  wire [2:0]  sect_hi  = raw_section(load_dn, ext_prof, split_ma);
  // Move only when the load is 30mA past the boundary in both directions
  wire        sect_move = (sect_lo == sect_hi) && (sect_raw != sect_q);

  always_ff @(posedge sys_clk) begin
    if (!reset_n)
      sect_q <= 3'd0;
    else if (clk_en && sect_move)
      sect_q <= sect_raw;
  end

  // Reported power: gain is Q1.7 so 0x80 is unity
  // The margin keeps the report at or above the sent power when no object is present
  wire [23:0] scaled = power_mw * gain_q[sect_q];
  wire [15:0] comp   = scaled[22:7] + {{8{ofs_q[sect_q][7]}}, ofs_q[sect_q]};
  wire [15:0] rpt_d  = comp + delta_q;

  // Share mode FOD
  wire [15:0] fod_lim  = (partner_rpp_mw >= split_q) ? lim_hi_q : lim_lo_q;
  wire [15:0] fod_diff = (tx_power_mw > partner_rpp_mw) ? tx_power_mw - partner_rpp_mw : 16'h0000;
  wire        fod_hit  = (st_q == wrfod_pkg::WRFOD_SHARE) && share_pt_valid && (fod_diff > fod_lim);

  // Ramp timer and report pacing
  // The ramp timer parks at its end count until the state moves on
  logic [31:0] ramp_q;
  logic [15:0] rpt_cnt_q;
  wire ramp_done = (ramp_q >= RAMP_CYC - 1);
  wire rpt_tick  = (rpt_cnt_q == 16'(`WRFOD_RPT_CYC - 1));

  // Sequencer
  always_comb begin
    st_d = st_q;
    case (st_q)
      wrfod_pkg::WRFOD_IDLE: begin
        // A tripped share session waits for the host to clear the trip
        if (autost && ext_vout_present && !fod_trip_q)
          st_d = wrfod_pkg::WRFOD_SHARE;
        else if (!inhibit && field_present)
          st_d = wrfod_pkg::WRFOD_NEGO;
      end
      wrfod_pkg::WRFOD_NEGO: begin
        if (inhibit)
          st_d = wrfod_pkg::WRFOD_END;
        else if (!field_present)
          st_d = wrfod_pkg::WRFOD_IDLE;
        else if (nego_done)
          st_d = ext_prof ? wrfod_pkg::WRFOD_XFER : wrfod_pkg::WRFOD_RAMP;
      end
      wrfod_pkg::WRFOD_RAMP: begin
        if (inhibit)
          st_d = wrfod_pkg::WRFOD_END;
        else if (rect_at_target || ramp_done)
          st_d = wrfod_pkg::WRFOD_XFER;
      end
      wrfod_pkg::WRFOD_XFER: begin
        if (inhibit)
          st_d = wrfod_pkg::WRFOD_END;
        else if (!field_present)
          st_d = wrfod_pkg::WRFOD_IDLE;
      end
      wrfod_pkg::WRFOD_SHARE: begin
        if (fod_hit || !ext_vout_present || !autost)
          st_d = wrfod_pkg::WRFOD_IDLE;
      end
      wrfod_pkg::WRFOD_END: begin
        // Hold off until the host releases inhibit and the field is gone
        if (!inhibit && !field_present)
          st_d = wrfod_pkg::WRFOD_IDLE;
      end
      default: st_d = wrfod_pkg::WRFOD_IDLE;
    endcase
  end

  wire entering_end = (st_d == wrfod_pkg::WRFOD_END) && (st_q != wrfod_pkg::WRFOD_END);
  wire entering_nego = (st_d == wrfod_pkg::WRFOD_NEGO) && (st_q != wrfod_pkg::WRFOD_NEGO);
  wire in_xfer = (st_q == wrfod_pkg::WRFOD_XFER) || (st_q == wrfod_pkg::WRFOD_RAMP);
  wire st_change = (st_d != st_q);
  wire any_fault = |faults;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_q       <= wrfod_pkg::WRFOD_IDLE;
      ramp_q     <= 32'd0;
      rpt_cnt_q  <= 16'd0;
      rpt_q      <= 16'd0;
      fod_trip_q <= 1'b0;
    end else if (clk_en) begin
      st_q      <= st_d;
      ramp_q    <= (st_q == wrfod_pkg::WRFOD_RAMP && !ramp_done) ? ramp_q + 32'd1 :
                   (st_q == wrfod_pkg::WRFOD_RAMP) ? ramp_q : 32'd0;
      rpt_cnt_q <= (in_xfer && !rpt_tick) ? rpt_cnt_q + 16'd1 : 16'd0;
      rpt_q     <= rpt_d;
      if (fod_hit)
        fod_trip_q <= 1'b1;
      else if (wr_ctrl && reg_wdata[`WRFOD_CTRL_ALERT_CLR])
        fod_trip_q <= 1'b0;
    end
  end

  // Alert: set wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!reset_n)
      alert_q <= 1'b0;
    else if (clk_en) begin
      if (any_fault || st_change || fod_hit)
        alert_q <= 1'b1;
      else if (wr_ctrl && reg_wdata[`WRFOD_CTRL_ALERT_CLR])
        alert_q <= 1'b0;
    end
  end
  assign host_alert_n_o  = 1'b0;
  assign host_alert_n_oe = alert_q;

  // Outgoing packets
  // One packet per cycle; the end packet wins so a stop is never held back
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pkt_q     <= '{kind: wrfod_pkg::WRFOD_PKT_NONE, value: 16'h0000};
      pkt_valid <= 1'b0;
    end else if (clk_en) begin
      pkt_valid <= 1'b0;
      if (entering_end) begin
        pkt_q     <= '{kind: wrfod_pkg::WRFOD_PKT_EPT, value: 16'h0000};
        pkt_valid <= 1'b1;
      end else if (entering_nego && ext_prof) begin
        pkt_q     <= '{kind: wrfod_pkg::WRFOD_PKT_QREF, value: qref_q};
        pkt_valid <= 1'b1;
      end else if (in_xfer && rpt_tick) begin
        pkt_q     <= '{kind: wrfod_pkg::WRFOD_PKT_RPP, value: rpt_d};
        pkt_valid <= 1'b1;
      end
    end
  end

  // Power good and regulator
  logic pg_q;
  wire reg_on = (st_q == wrfod_pkg::WRFOD_XFER);
  wire pg_set = ext_prof && !ctrl_q[`WRFOD_CTRL_PG_REG] ? (reg_on || (st_q == wrfod_pkg::WRFOD_NEGO && nego_done))
                                                        : reg_on;
  always_ff @(posedge sys_clk) begin
    if (!reset_n)
      pg_q <= 1'b0;
    else if (clk_en)
      pg_q <= pg_set;
  end
  assign power_good_out    = pg_q;
  assign main_regulator_en = reg_on;
  assign rect_protect_en   = 1'b1;
  assign share_active      = (st_q == wrfod_pkg::WRFOD_SHARE);

  // Register read, data one cycle after the strobe
  // Unmapped words read zero; the clear bit of CTRL is write-only and reads zero
  wire [15:0] fod_rd = fod_rel[0] ? {8'h00, ofs_q[fod_idx]} : {8'h00, gain_q[fod_idx]};
  wire [15:0] rd_mux =
    (reg_addr == `WRFOD_REG_CTRL)   ? {12'h000, ctrl_q} :
    (reg_addr == `WRFOD_REG_STATUS) ? {8'h00, fod_trip_q, alert_q, pg_q, share_active, 1'b0, st_q} :
    (reg_addr == `WRFOD_REG_QREF)   ? qref_q :
    (reg_addr == `WRFOD_REG_DELTA)  ? delta_q :
    (reg_addr == `WRFOD_REG_SPLIT)  ? split_q :
    (reg_addr == `WRFOD_REG_LIM_HI) ? lim_hi_q :
    (reg_addr == `WRFOD_REG_LIM_LO) ? lim_lo_q :
    (reg_addr == `WRFOD_REG_RPT)    ? rpt_q :
    (reg_addr == `WRFOD_REG_SECTION) ? {13'h0000, sect_q} :
    ((reg_addr >= `WRFOD_REG_FOD_FIRST) && (reg_addr <= `WRFOD_REG_FOD_LAST)) ? fod_rd : 16'h0000;
  always_ff @(posedge sys_clk) begin
    if (!reset_n)
      reg_rdata <= 16'h0000;
    else if (clk_en)
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
  end

  // Checks
  // All but the limit pick wait for the clock enable, so a frozen block never trips them
  a_inhibit_ends: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && inhibit && (st_q == wrfod_pkg::WRFOD_XFER) |=> pkt_valid && pkt_q.kind == wrfod_pkg::WRFOD_PKT_EPT)
    else $error("no end packet after inhibit");
  a_no_connect: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && inhibit && st_q == wrfod_pkg::WRFOD_IDLE |=> st_q != wrfod_pkg::WRFOD_NEGO)
    else $error("connected while inhibited");
  a_pg_basic: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && !ext_prof && $rose(main_regulator_en) |=> power_good_out)
    else $error("power good late");
  a_autostart: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && st_q == wrfod_pkg::WRFOD_IDLE && autost && ext_vout_present && !fod_trip_q |=> share_active)
    else $error("share mode not started");
  a_rpp_value: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && in_xfer && rpt_tick && !inhibit |=> pkt_q.value == $past(comp) + $past(delta_q))
    else $error("reported power wrong");
  a_fod_stop: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && fod_hit |=> !share_active)
    else $error("share transfer not stopped");
  a_limit_pick: assert property (@(posedge sys_clk) disable iff (!reset_n)
    partner_rpp_mw < split_q |-> fod_lim == lim_lo_q)
    else $error("wrong limit");
  a_ramp_bound: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && st_q == wrfod_pkg::WRFOD_RAMP && rect_at_target && !inhibit |=> main_regulator_en)
    else $error("regulator not enabled");
  a_section_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && load_ma >= 16'h0384 |=> sect_q == 3'd5)
    else $error("section not five");
  a_section_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && (sect_lo != sect_hi) |=> sect_q == $past(sect_q))
    else $error("section moved inside hysteresis band");
  a_alert_fault: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && any_fault |=> host_alert_n_oe && !host_alert_n_o)
    else $error("alert not raised on fault");
  a_qref_pkt: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && entering_nego && ext_prof |=> pkt_valid && pkt_q.kind == wrfod_pkg::WRFOD_PKT_QREF
    && pkt_q.value == $past(qref_q))
    else $error("reference quality packet missing");
  a_pg_ext: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && ext_prof && !ctrl_q[`WRFOD_CTRL_PG_REG] && st_q == wrfod_pkg::WRFOD_NEGO
    && nego_done |=> power_good_out)
    else $error("power good late after negotiation");
  a_share_latch: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && fod_hit |=> ##1 !share_active)
    else $error("share mode restarted after trip");
  c_share: cover property (@(posedge sys_clk) fod_hit);
  c_ept: cover property (@(posedge sys_clk) pkt_valid && pkt_q.kind == wrfod_pkg::WRFOD_PKT_EPT);
  c_ramp_timeout: cover property (@(posedge sys_clk) st_q == wrfod_pkg::WRFOD_RAMP && ramp_done);
  c_rpp: cover property (@(posedge sys_clk) pkt_valid && pkt_q.kind == wrfod_pkg::WRFOD_PKT_RPP);
  c_qref: cover property (@(posedge sys_clk) pkt_valid && pkt_q.kind == wrfod_pkg::WRFOD_PKT_QREF);
endmodule // wrfod_core
`default_nettype wire

// *** sim/wrfod_partner.sv ***
// Transmitter and host pull-up model facing the receiver block.
// Assumes the bench moves place and slow_rect just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module wrfod_partner #(
  parameter int NEGO_DLY = 20
) (
  input  wire logic sys_clk,
  input  wire logic place,
  input  wire logic slow_rect,
  input  wire logic alert_o,
  input  wire logic alert_oe,
  output logic      alert_wire,
  output logic      field_present,
  output logic      nego_done,
  output logic      rect_at_target
);
  int unsigned cnt_q;
  // Released open-drain line floats up to the host rail
  assign alert_wire    = alert_oe ? alert_o : 1'b1;
  assign field_present = place;
  always_ff @(posedge sys_clk) begin
    if (!place) begin
      cnt_q          <= 0;
      nego_done      <= 1'b0;
      rect_at_target <= 1'b0;
    end else begin
      cnt_q          <= cnt_q + 1;
      nego_done      <= (cnt_q >= NEGO_DLY);
      // A slow rectifier never reaches target, so only the timer can help
      rect_at_target <= !slow_rect && (cnt_q >= NEGO_DLY + 10);
    end
  end
endmodule // wrfod_partner
`default_nettype wire

// *** sim/wrfod_core_bench.sv ***
// Self-checking bench for the receiver FOD and host-pin block.
// Assumes the design, its package and wrfod_cfg.svh are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "wrfod_cfg.svh"
module wrfod_core_bench;
  logic        sys_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, clk_en = 1;
  logic [7:0]  reg_addr = '0;
  logic [15:0] reg_wdata = '0, reg_rdata, load_ma = '0, power_mw = '0, tx_power_mw = '0, partner_rpp_mw = '0;
  logic        transfer_inhibit = 0, share_mode_autostart = 0, ext_vout_present = 0, share_pt_valid = 0;
  logic        place = 0, slow_rect = 0, field_present, nego_done, rect_at_target;
  logic        alert_o, alert_oe, alert_wire, power_good_out, main_regulator_en, rect_protect_en;
  logic        share_active, pkt_valid;
  wrfod_pkg::wrfod_faults_t faults = '0;
  wrfod_pkg::wrfod_packet_t pkt_q;
  int          num_errors = 0, n_compared = 0, cycles = 0;

  always #4 sys_clk = ~sys_clk;

  wrfod_core #(.RAMP_CYC(100)) dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .transfer_inhibit(transfer_inhibit), .share_mode_autostart(share_mode_autostart),
    .field_present(field_present), .nego_done(nego_done), .rect_at_target(rect_at_target),
    .ext_vout_present(ext_vout_present), .share_pt_valid(share_pt_valid), .load_ma(load_ma),
    .power_mw(power_mw), .tx_power_mw(tx_power_mw), .partner_rpp_mw(partner_rpp_mw), .faults(faults),
    .host_alert_n_o(alert_o), .host_alert_n_oe(alert_oe), .power_good_out(power_good_out),
    .main_regulator_en(main_regulator_en), .rect_protect_en(rect_protect_en),
    .share_active(share_active), .pkt_q(pkt_q), .pkt_valid(pkt_valid));

  wrfod_partner partner (.sys_clk(sys_clk), .place(place), .slow_rect(slow_rect), .alert_o(alert_o),
    .alert_oe(alert_oe), .alert_wire(alert_wire), .field_present(field_present),
    .nego_done(nego_done), .rect_at_target(rect_at_target));

  task automatic results();
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      results();
    end
  end

  task automatic chk(input string name, input logic [17:0] exp, input logic [17:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Every scenario starts from a fresh reset so a tripped state never leaks forward
  task automatic rst();
    @(posedge sys_clk);
    reset_n <= 0;
    place <= 0;
    slow_rect <= 0;
    transfer_inhibit <= 0;
    share_mode_autostart <= 0;
    ext_vout_present <= 0;
    share_pt_valid <= 0;
    load_ma <= '0;
    faults <= '0;
    settle(16);
    @(posedge sys_clk);
    reset_n <= 1;
    settle(4);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge sys_clk);
    reg_rd <= 0;
    #1;
    chk(name, {2'b00, exp}, {2'b00, reg_rdata});
  endtask

  // Packets pulse for one cycle, so poll every cycle under a bound
  task automatic wait_pkt(input int n);
    for (int i = 0; i < n && pkt_valid !== 1'b1; i++) settle(1);
  endtask

  task automatic t_regs();
    rd("qref", `WRFOD_REG_QREF, 16'h001E);
    rd("delta", `WRFOD_REG_DELTA, 16'h01F4);
    rd("split", `WRFOD_REG_SPLIT, 16'h1388);
    rd("lim_hi", `WRFOD_REG_LIM_HI, 16'h02BC);
    rd("lim_lo", `WRFOD_REG_LIM_LO, 16'h01F4);
    rd("gain0", `WRFOD_REG_FOD_FIRST, 16'h0080);
    rd("unmapped", 8'h50, 16'h0000);
    chk("pg_rst", 18'h0_0000, {17'h0, power_good_out});
    chk("alert_idle", 18'h0_0001, {17'h0, alert_wire});
    faults <= 3'b100;
    settle(8);
    chk("alert_fault", 18'h0_0000, {17'h0, alert_wire});
  endtask

  task automatic t_sections();
    logic [15:0] loads [7] = '{16'd330, 16'd420, 16'd600, 16'd720, 16'd920, 16'd860, 16'd830};
    logic [15:0] secs  [7] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0005, 16'h0004};
    foreach (loads[i]) begin
      load_ma <= loads[i];
      settle(8);
      rd("section", `WRFOD_REG_SECTION, secs[i]);
    end
    wr(`WRFOD_REG_CTRL, 16'h0004);
    load_ma <= 16'd300;
    settle(8);
    rd("section_hiv", `WRFOD_REG_SECTION, 16'h0000);
    wr(`WRFOD_REG_CTRL, 16'h0001);
    load_ma <= 16'd50;
    settle(8);
    rd("section_diode", `WRFOD_REG_SECTION, 16'h0006);
    load_ma <= 16'd200;
    settle(8);
    rd("section_ext0", `WRFOD_REG_SECTION, 16'h0000);
  endtask

  task automatic t_basic_xfer();
    wr(8'h68, 16'h0040);
    wr(8'h69, 16'h0010);
    load_ma <= 16'd100;
    power_mw <= 16'd1000;
    place <= 1;
    for (int i = 0; i < 200 && main_regulator_en !== 1'b1; i++) settle(1);
    chk("reg_on", 18'h0_0001, {17'h0, main_regulator_en});
    settle(2);
    chk("pg_basic", 18'h0_0001, {17'h0, power_good_out});
    wait_pkt(7000);
    chk("rpp", {wrfod_pkg::WRFOD_PKT_RPP, 16'h03F8}, pkt_q);
    settle(1);
    wait_pkt(7000);
    chk("rpp_again", {wrfod_pkg::WRFOD_PKT_RPP, 16'h03F8}, pkt_q);
    settle(1);
    wr(`WRFOD_REG_CTRL, 16'h0008);
    settle(2);
    chk("alert_clr", 18'h0_0001, {17'h0, alert_wire});
    transfer_inhibit <= 1;
    wait_pkt(20);
    chk("ept", {wrfod_pkg::WRFOD_PKT_EPT, 16'h0000}, {pkt_q.kind, 16'h0000});
    settle(2);
    chk("reg_off", 18'h0_0000, {17'h0, main_regulator_en});
    chk("protect", 18'h0_0001, {17'h0, rect_protect_en});
    chk("alert_state", 18'h0_0000, {17'h0, alert_wire});
  endtask

  task automatic t_timer();
    slow_rect <= 1;
    place <= 1;
    for (int i = 0; i < 100 && nego_done !== 1'b1; i++) settle(1);
    // A frozen block must neither leave negotiation nor run its ramp timer
    clk_en <= 0;
    settle(90);
    chk("reg_frozen", 18'h0_0000, {17'h0, main_regulator_en});
    clk_en <= 1;
    settle(60);
    chk("reg_early", 18'h0_0000, {17'h0, main_regulator_en});
    settle(60);
    chk("reg_timer", 18'h0_0001, {17'h0, main_regulator_en});
  endtask

  task automatic t_inhibit_hold();
    transfer_inhibit <= 1;
    settle(4);
    place <= 1;
    settle(100);
    rd("state_idle", `WRFOD_REG_STATUS, 16'h0000);
    chk("no_reg", 18'h0_0000, {17'h0, main_regulator_en});
  endtask

  task automatic t_ext();
    wr(`WRFOD_REG_CTRL, 16'h0001);
    place <= 1;
    wait_pkt(60);
    chk("qref_pkt", {wrfod_pkg::WRFOD_PKT_QREF, 16'h001E}, pkt_q);
    chk("pg_nego", 18'h0_0000, {17'h0, power_good_out});
    settle(60);
    chk("pg_ext", 18'h0_0001, {17'h0, power_good_out});
  endtask

  task automatic t_share(input logic [15:0] received_power_report, input logic [15:0] ok_tx, input logic [15:0] bad_tx);
    share_mode_autostart <= 1;
    share_pt_valid <= 1;
    partner_rpp_mw <= received_power_report;
    tx_power_mw <= ok_tx;
    settle(10);
    chk("share_wait", 18'h0_0000, {17'h0, share_active});
    ext_vout_present <= 1;
    settle(10);
    chk("share_on", 18'h0_0001, {17'h0, share_active});
    settle(30);
    chk("share_keep", 18'h0_0001, {17'h0, share_active});
    tx_power_mw <= bad_tx;
    settle(10);
    chk("share_trip", 18'h0_0000, {17'h0, share_active});
    rd("trip_flag", `WRFOD_REG_STATUS, 16'h00C0);
  endtask

  initial begin
    rst();
    t_regs();
    rst();
    t_sections();
    rst();
    t_basic_xfer();
    rst();
    t_timer();
    rst();
    t_inhibit_hold();
    rst();
    t_ext();
    rst();
    t_share(16'h1770, 16'h19C8, 16'h1A90);
    rst();
    t_share(16'h03E8, 16'h0578, 16'h0640);
    results();
  end
endmodule // wrfod_core_bench
`default_nettype wire
